/* hdl/pgt_timer.sv */
// Top of the power gating interval timer.
//
// Behaviour
// - Strap high: enable rises at each interval start, forever.
// - Strap low: one enable pulse after power-up, more only by manual.
// - Unacknowledged pulse lasts interval minus 50 ms, then 50 ms low.
// - Only an acknowledge rising edge counts; it drops the enable.
// - Only the first acknowledge edge in an interval is used.
// - Enable goes high once the interval is known, at interval start.
// - Manual power-on is ignored while the enable is high.
// - One interval measurement after reset, then mode from the strap.
// - Manual pin high after startup is manual power-on, no remeasure.
// - Manual during reset or measurement aborts it; restart on release.
// - Manual valid only if high 20 ms within a 30 ms window.
// - Manual pin debounced on both edges; glitches only abort a measurement.
// - Enable rises within 10 ms of a valid manual power-on.
// - Manual clears counters; counting resumes when pin returns low.
// - Enable stays high as long as the manual pin is held high.
// - Acknowledge edges while the manual pin is high are ignored.
// - One-shot manual gives one full pulse, ended early by acknowledge.
// - Interval is selectable from 100 ms to 7200 s.
// - Interval measurement takes at most 120 ms.
`timescale 1ns/100ps
module pgt_timer
  import pgt_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_CYCLES
)
(
  input  wire logic             ref_clk_in,        // 200 MHz clock.
  input  wire logic             rst_n_in,          // Async reset, low.
  input  wire logic             mode_strap_in,     // High: timer mode.
  input  wire logic             ack_in,            // Host acknowledge.
  input  wire logic             interval_manual_pin_in, // Manual pin.
  input  wire logic [IVL_W-1:0] interval_code_in,  // Interval in ms.
  input  wire logic             interval_valid_in, // Code strobe.
  output logic                  power_enable_out,  // Regulator enable.
  output logic                  measure_start_out, // Start measurement.
  output logic                  measure_busy_out,  // Analog chain on pin.
  output logic                  measure_abort_out, // Measurement aborted.
  output logic                  timer_mode_out     // Mode in use.
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release.
  // The reset pin drops every register at once, but its release is
  // retimed through two flip-flops so that no register leaves reset on a
  // different edge from its neighbours.  Everything below the retimed
  // copy sees one clean release.

  logic rst_sync1_reg;
  logic rst_sync2_reg;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tick and manual pin qualification.
  // The divider turns the fast clock into the millisecond tick that every
  // counter of the block steps on.  The debouncer decides when a level on
  // the manual pin is real and hands the core both the raw synchronised
  // level and the debounced level with its rising pulse.

  pgt_link_if link ();

  pgt_tick_gen #(
    .DIVIDE   (TICK_DIVIDE)
  ) u_tick (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_sync2_reg),
    .link     (link.tick_src)
  );

  pgt_debounce u_deb (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_sync2_reg),
    .pin_in   (interval_manual_pin_in),
    .link     (link.deb)
  );

  ////////////////////////////////////////////////////////////////////////
  // Core state.
  // All core state lives in one packed struct: the three-stage
  // synchronisers for the acknowledge and the mode strap, the mode and the
  // interval latched at the end of the measurement, the interval counter,
  // the enable itself and the measurement handshake towards the analog
  // stage.

  typedef struct packed {
    pgt_state_t        fsm;

    // Acknowledge synchroniser and its accepted level.
    logic              ack_s1;
    logic              ack_s2;
    logic              ack_s3;
    logic              ack_lvl;

    // Mode strap synchroniser and its settled level.
    logic              mode_s1;
    logic              mode_s2;
    logic              mode_s3;
    logic              mode_lvl;

    // Settings latched by the measurement and the interval counter.
    logic              mode_timer;
    logic              started;
    logic [IVL_W-1:0]  interval;
    logic [IVL_W-1:0]  count;

    // Enable and acknowledge bookkeeping.
    logic              enable;
    logic              ack_done;

    // Handshake towards the analog measurement stage.
    logic              meas_start;
    logic              meas_busy;
    logic              meas_abort;
    logic [MEAS_W-1:0] meas_cnt;
  } pgt_core_st_t;

  pgt_core_st_t st_reg;
  pgt_core_st_t st_next;

  logic             ack_rise;
  logic [IVL_W-1:0] code_clamped;
  logic [IVL_W-1:0] pulse_end;

  // An acknowledge counts once the second and third stages agree high
  // while the accepted level is still low.  The accepted level then
  // follows the pin, so a held acknowledge is taken only once.
  assign ack_rise = (st_reg.ack_s2 == st_reg.ack_s3) && st_reg.ack_s3 &&
                    !st_reg.ack_lvl;

  // A code outside the selectable range is pulled to the nearest limit,
  // so a faulty conversion can never give a zero or runaway interval.
  always_comb
  begin
    if (interval_code_in < IVL_MIN_TICKS)
      code_clamped = IVL_MIN_TICKS;
    else if (interval_code_in > IVL_MAX_TICKS)
      code_clamped = IVL_MAX_TICKS;
    else
      code_clamped = interval_code_in;
  end

  // The enable falls this many ticks into the interval, which leaves the
  // trailing low gap before the next interval starts.
  assign pulse_end = st_reg.interval - OFF_GAP_TICKS;

  always_comb
  begin
    st_next            = st_reg;
    st_next.ack_s1     = ack_in;
    st_next.ack_s2     = st_reg.ack_s1;
    st_next.ack_s3     = st_reg.ack_s2;
    st_next.mode_s1    = mode_strap_in;
    st_next.mode_s2    = st_reg.mode_s1;
    st_next.mode_s3    = st_reg.mode_s2;
    st_next.meas_start = 1'b0;
    st_next.meas_abort = 1'b0;
    if (st_reg.ack_s2 == st_reg.ack_s3)
      st_next.ack_lvl = st_reg.ack_s3;
    if (st_reg.mode_s2 == st_reg.mode_s3)
      st_next.mode_lvl = st_reg.mode_s3;

    // The synchronisers and the one-cycle pulses above run in every state;
    // the state machine below only overrides what it owns.
    unique case (st_reg.fsm)
      PGT_MEASURE:
      begin
        // The analog chain owns the pin here; any high level on it, raw or
        // debounced, means the user is pressing the switch.
        // The first cycle after reset launches the single measurement.
        if (!st_reg.started)
        begin
          st_next.started    = 1'b1;
          st_next.meas_start = 1'b1;
          st_next.meas_busy  = 1'b1;
          st_next.meas_cnt   = '0;
        end
        else if (link.pin_level || link.man_high)
        begin
          st_next.fsm        = PGT_ABORT;
          st_next.meas_busy  = 1'b0;
          st_next.meas_abort = 1'b1;
        end
        // A finished conversion latches the interval and the mode and
        // opens the first interval with the enable high.
        else if (interval_valid_in)
        begin
          st_next.fsm        = PGT_RUN;
          st_next.interval   = code_clamped;
          st_next.mode_timer = st_reg.mode_lvl;
          st_next.meas_busy  = 1'b0;
          st_next.count      = '0;
          st_next.enable     = 1'b1;
          st_next.ack_done   = 1'b0;
        end
        else if (link.tick)
        begin
          // A conversion that overruns its longest time is started over.
          if (st_reg.meas_cnt + 1'b1 == MEAS_MAX_TICKS)
          begin
            st_next.meas_cnt   = '0;
            st_next.meas_start = 1'b1;
          end
          else
          begin
            st_next.meas_cnt = st_reg.meas_cnt + 1'b1;
          end
        end
      end

      PGT_ABORT:
      begin
        // The analog chain has let go of the pin.  Wait until both the raw
        // and the debounced level are low before measuring again, so the
        // switch current never disturbs a conversion.
        if (!link.pin_level && !link.man_high)
        begin
          st_next.fsm        = PGT_MEASURE;
          st_next.meas_start = 1'b1;
          st_next.meas_busy  = 1'b1;
          st_next.meas_cnt   = '0;
        end
      end

      PGT_RUN:
      begin
        // Normal operation.  The counter steps once per tick from the start
        // of the interval; the enable drops at the pulse end or on the first
        // accepted acknowledge, and rises again at the next interval start
        // in timer mode.
        if (link.man_rise && !st_reg.enable)
        begin
          // The pin is no longer measured once running.
          st_next.fsm      = PGT_MANUAL;
          st_next.enable   = 1'b1;
          st_next.count    = '0;
          st_next.ack_done = 1'b0;
        end
        else
        begin
          // A manual request while the enable is high changes nothing.
          if (ack_rise && !st_reg.ack_done && !link.man_high)
          begin
            st_next.enable   = 1'b0;
            st_next.ack_done = 1'b1;
          end

          // At the interval end the count and the acknowledge bookkeeping
          // restart whatever the mode.
          if (link.tick)
          begin
            if (st_reg.count == st_reg.interval - 1'b1)
            begin
              st_next.count    = '0;
              st_next.ack_done = 1'b0;
              if (st_reg.mode_timer)
              begin
                st_next.enable = 1'b1;
              end
              else
              begin
                st_next.fsm    = PGT_IDLE;
                st_next.enable = 1'b0;
              end
            end
            else
            begin
              st_next.count = st_reg.count + 1'b1;
              if (st_reg.count + 1'b1 == pulse_end)
                st_next.enable = 1'b0;
            end
          end
        end
      end

      PGT_IDLE:
      begin
        // One-shot mode after its pulse: only a valid manual power-on
        // leaves this state, and the enable stays low until it does.  The
        // acknowledge has nothing to end here and is not looked at.
        if (link.man_rise)
        begin
          st_next.fsm      = PGT_MANUAL;
          st_next.enable   = 1'b1;
          st_next.count    = '0;
          st_next.ack_done = 1'b0;
        end
      end

      // Held here for as long as the debounced pin is high, so an extended
      // press stretches the pulse; the release starts the counting.
      PGT_MANUAL:
      begin
        // Counters stay cleared and the enable held while the pin is high.
        st_next.enable = 1'b1;
        st_next.count  = '0;
        if (!link.man_high)
          st_next.fsm = PGT_RUN;
      end
    endcase
  end

  // The reset value starts the measurement on the first free edge.
  always_ff @(posedge ref_clk_in or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
      st_reg <= '{fsm: PGT_MEASURE, default: '0};
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.
  // Every output is a field of the registered state, so nothing outside
  // the block sees a combinational glitch, in particular not the
  // regulator enable.

  assign power_enable_out  = st_reg.enable;
  assign measure_start_out = st_reg.meas_start;
  assign measure_busy_out  = st_reg.meas_busy;
  assign measure_abort_out = st_reg.meas_abort;
  assign timer_mode_out    = st_reg.mode_timer;

endmodule

/* hdl/pgt_pkg.sv */
// Constants and types shared by the power gating interval timer.
package pgt_pkg;

  // Clock and the internal counting tick.
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS * 1000 / CLK_PERIOD_PS;
  localparam int TICK_MS        = 1;

  // Interval limits and the trailing low gap, in milliseconds.
  localparam int IVL_W          = 23;
  localparam int IVL_MIN_MS     = 100;
  localparam int IVL_MAX_MS     = 7200000;
  localparam int OFF_GAP_MS     = 50;
  localparam logic [IVL_W-1:0] IVL_MIN_TICKS =
    IVL_W'(IVL_MIN_MS / TICK_MS);
  localparam logic [IVL_W-1:0] IVL_MAX_TICKS =
    IVL_W'(IVL_MAX_MS / TICK_MS);
  localparam logic [IVL_W-1:0] OFF_GAP_TICKS =
    IVL_W'(OFF_GAP_MS / TICK_MS);

  // Interval measurement at startup, in milliseconds.
  localparam int MEAS_W         = 8;
  localparam int MEAS_MAX_MS    = 120;
  localparam logic [MEAS_W-1:0] MEAS_MAX_TICKS =
    MEAS_W'(MEAS_MAX_MS / TICK_MS);

  // Manual power-on qualification, in milliseconds.
  localparam int DEB_W          = 6;
  localparam int DEB_MS         = 20;
  localparam int OBS_MS         = 30;
  localparam logic [DEB_W-1:0] DEB_TICKS = DEB_W'(DEB_MS / TICK_MS);
  localparam logic [DEB_W-1:0] OBS_TICKS = DEB_W'(OBS_MS / TICK_MS);

  localparam int TICK_W         = 18;

  typedef enum logic [2:0] {
    PGT_MEASURE,
    PGT_ABORT,
    PGT_RUN,
    PGT_IDLE,
    PGT_MANUAL
  } pgt_state_t;

endpackage

/* hdl/pgt_link_if.sv */
// Interface between the timer core, its tick source and the debouncer.
`timescale 1ns/100ps
interface pgt_link_if;
  logic tick;      // One-cycle pulse every tick period.
  logic pin_level; // Synchronised, undebounced manual pin level.
  logic man_high;  // Debounced manual pin level.
  logic man_rise;  // One-cycle pulse on a valid manual power-on.

  modport tick_src (output tick);
  modport deb (input tick, output pin_level, output man_high,
               output man_rise);
  modport core (input tick, input pin_level, input man_high,
                input man_rise);
endinterface

/* hdl/pgt_tick_gen.sv */
// Divider that makes the internal counting tick.
`timescale 1ns/100ps
module pgt_tick_gen
  import pgt_pkg::*;
#(
  parameter int DIVIDE = TICK_CYCLES
)
(
  input  wire logic clk_in,   // System clock.
  input  wire logic rst_n_in, // Synchronised reset, active low.
  pgt_link_if.tick_src link   // Tick output.
);

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              tick;
  } pgt_tick_st_t;

  pgt_tick_st_t st_reg;
  pgt_tick_st_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == TICK_W'(DIVIDE - 1))
    begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign link.tick = st_reg.tick;

endmodule

/* hdl/pgt_debounce.sv */
// Synchroniser and two-edge debouncer for the manual power-on pin.
`timescale 1ns/100ps
module pgt_debounce
  import pgt_pkg::*;
(
  input  wire logic clk_in,   // System clock.
  input  wire logic rst_n_in, // Synchronised reset, active low.
  input  wire logic pin_in,   // Raw manual pin.
  pgt_link_if.deb   link      // Levels and the valid pulse.
);

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    logic             fast;
    logic             deb;
    logic             rise;
    logic             obs;
    logic [DEB_W-1:0] win;
    logic [DEB_W-1:0] hits;
  } pgt_deb_st_t;

  pgt_deb_st_t st_reg;
  pgt_deb_st_t st_next;

  // A new level must hold for the debounce time inside one observation
  // window; otherwise the window closes and the old level stays.
  always_comb
  begin
    st_next      = st_reg;
    st_next.s1   = pin_in;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.rise = 1'b0;
    if (st_reg.s2 == st_reg.s3)
      st_next.fast = st_reg.s3;
    if (!st_reg.obs)
    begin
      if (st_reg.fast != st_reg.deb)
      begin
        st_next.obs  = 1'b1;
        st_next.win  = '0;
        st_next.hits = '0;
      end
    end
    else if (link.tick)
    begin
      st_next.win = st_reg.win + 1'b1;
      if (st_reg.fast != st_reg.deb)
        st_next.hits = st_reg.hits + 1'b1;
      if (st_reg.fast != st_reg.deb && st_reg.hits + 1'b1 == DEB_TICKS)
      begin
        st_next.deb  = ~st_reg.deb;
        st_next.rise = ~st_reg.deb;
        st_next.obs  = 1'b0;
      end
      else if (st_reg.win + 1'b1 == OBS_TICKS)
      begin
        st_next.obs = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign link.pin_level = st_reg.fast;
  assign link.man_high  = st_reg.deb;
  assign link.man_rise  = st_reg.rise;

endmodule

/* tb/pgt_host_model.sv */
// Host and analog measurement stage seen from the timer's pins.
`timescale 1ns/100ps
module pgt_host_model
  import pgt_pkg::*;
#(
  parameter int               MEAS_DLY = 1000,
  parameter logic [IVL_W-1:0] CODE     = 23'h000064
)
(
  input  wire logic             clk_in,     // Clock.
  input  wire logic             enable_in,  // Regulator enable.
  input  wire logic             start_in,   // Measurement start.
  input  wire logic             busy_in,    // Measurement busy.
  input  wire logic [31:0]      ack_dly_in, // Cycles to ack, 0 never.
  output logic                  ack_out,    // Acknowledge.
  output logic [IVL_W-1:0]      code_out,   // Interval code.
  output logic                  valid_out   // Code strobe.
);
  int n;

  // Outside the strobe the code is meaningless, so show its inverse.
  assign code_out = valid_out ? CODE : ~CODE;

  initial
  begin
    valid_out = 1'h0;
    forever
    begin
      @(posedge clk_in);
      if (start_in)
      begin
        n = 0;
        while (busy_in && n < MEAS_DLY)
        begin
          @(posedge clk_in);
          n++;
        end
        if (busy_in)
        begin
          valid_out <= 1'h1;
          @(posedge clk_in);
          valid_out <= 1'h0;
        end
      end
    end
  end

  initial
  begin
    ack_out = 1'h0;
    forever
    begin
      @(posedge enable_in);
      if (ack_dly_in != 0)
      begin
        repeat (ack_dly_in) @(posedge clk_in);
        ack_out <= 1'h1;
        repeat (24) @(posedge clk_in);
        ack_out <= 1'h0;
      end
    end
  end
endmodule

/* tb/pgt_timer_assertions.sv */
// Port checker for the power gating interval timer.
`timescale 1ns/100ps
module pgt_timer_chk
  import pgt_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_CYCLES
)
(
  input wire logic             ref_clk_in,             // Clock.
  input wire logic             rst_n_in,               // Reset.
  input wire logic             mode_strap_in,          // Strap.
  input wire logic             ack_in,                 // Acknowledge.
  input wire logic             interval_manual_pin_in, // Manual pin.
  input wire logic [IVL_W-1:0] interval_code_in,       // Code.
  input wire logic             interval_valid_in,      // Strobe.
  input wire logic             power_enable_out,       // Enable.
  input wire logic             measure_start_out,      // Start.
  input wire logic             measure_busy_out,       // Busy.
  input wire logic             measure_abort_out,      // Abort.
  input wire logic             timer_mode_out          // Mode.
);
  localparam int T = TICK_DIVIDE;
  int   hi_reg;
  int   lo_reg;
  int   ph_reg;
  int   ivl_reg;
  logic done_reg;
  logic acc_reg;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      hi_reg   <= 0;
      lo_reg   <= 0;
      ph_reg   <= 0;
      ivl_reg  <= 0;
      done_reg <= 1'h0;
      acc_reg  <= 1'h0;
    end
    else
    begin
      hi_reg <= power_enable_out ? hi_reg + 1 : 0;
      lo_reg <= interval_manual_pin_in ? 0 : lo_reg + 1;
      ph_reg <= interval_manual_pin_in ? ph_reg + 1 : 0;
      if (measure_busy_out && interval_valid_in)
      begin
        ivl_reg  <= int'(interval_code_in);
        done_reg <= 1'h1;
      end
      if (ph_reg == 0)
        acc_reg <= done_reg && !power_enable_out;
    end

  ////////////////////////////////////////
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  start_busy_a: assert property (
    measure_start_out |-> measure_busy_out) else $error("start idle");
  valid_en_a: assert property (
    measure_busy_out && interval_valid_in |=>
    power_enable_out && !measure_busy_out) else $error("no enable");
  abort_busy_a: assert property (
    measure_abort_out |-> ##[0:1] !measure_busy_out) else $error("abort");
  mode_pick_a: assert property (
    $rose(power_enable_out) && $past(measure_busy_out) |->
    timer_mode_out == mode_strap_in) else $error("bad mode");
  no_remeas_a: assert property (
    done_reg |-> !measure_start_out && !measure_busy_out)
    else $error("remeasure");
  ack_drop_a: assert property (
    $rose(ack_in) && power_enable_out && lo_reg > 80*T |->
    ##[2:8] !power_enable_out) else $error("ack ignored");
  en_len_a: assert property (
    done_reg && hi_reg > (ivl_reg - 49)*T |-> lo_reg < (ivl_reg - 26)*T)
    else $error("pulse too long");
  one_shot_a: assert property (
    $rose(power_enable_out) && !timer_mode_out && $past(done_reg) |->
    lo_reg < 40*T) else $error("extra pulse");
  man_hold_a: assert property (
    acc_reg && ph_reg > 32*T |-> power_enable_out)
    else $error("manual not held");

  cover property ($fell(power_enable_out) && hi_reg > 40*T);
  cover property (measure_abort_out);
  cover property (acc_reg && ph_reg == 33*T);
endmodule

bind pgt_timer pgt_timer_chk #(.TICK_DIVIDE(TICK_DIVIDE)) chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .mode_strap_in(mode_strap_in), .ack_in(ack_in),
  .interval_manual_pin_in(interval_manual_pin_in),
  .interval_code_in(interval_code_in),
  .interval_valid_in(interval_valid_in),
  .power_enable_out(power_enable_out),
  .measure_start_out(measure_start_out),
  .measure_busy_out(measure_busy_out),
  .measure_abort_out(measure_abort_out),
  .timer_mode_out(timer_mode_out));

/* tb/test_power_gating_interval_timer.sv */
// Self-checking testbench for the power gating interval timer.
`timescale 1ns/100ps
`define CHK(a, b, m) \
  begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t %s", $time, m); end end
module test_power_gating_interval_timer;
  import pgt_pkg::*;
  localparam int T = 20;
  logic             clk = 1'h0;
  logic             rst_n = 1'h0;
  logic             strap = 1'h1;
  logic             pin = 1'h0;
  logic             ack;
  logic [IVL_W-1:0] code;
  logic             valid;
  logic             en, st, busy, ab, tm;
  int               ack_dly = 0;
  int               err_count = 0;
  int               n_tests = 0;

  initial forever #2.5 clk = ~clk;

  pgt_timer #(.TICK_DIVIDE(T)) uut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .mode_strap_in(strap),
    .ack_in(ack), .interval_manual_pin_in(pin), .interval_code_in(code),
    .interval_valid_in(valid), .power_enable_out(en),
    .measure_start_out(st), .measure_busy_out(busy),
    .measure_abort_out(ab), .timer_mode_out(tm));
  pgt_host_model #(.MEAS_DLY(50*T)) host (
    .clk_in(clk), .enable_in(en), .start_in(st), .busy_in(busy),
    .ack_dly_in(ack_dly), .ack_out(ack), .code_out(code),
    .valid_out(valid));

  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic rst_to(input logic s);
    rst_n <= 1'h0;
    strap <= s;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
  endtask

  task automatic wt(input logic v, input int lim, output int n);
    n = 0;
    while (en !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic rng(input int n, input int lo, input int hi, string m);
    `CHK(n >= lo && n <= hi, 1'h1, m);
  endtask

  task automatic hold(input logic v, input int k, string m);
    logic bad;
    bad = 1'h0;
    repeat (k)
    begin
      @(posedge clk);
      if (en !== v)
        bad = 1'h1;
    end
    `CHK(bad, 1'h0, m);
  endtask

  ////////////////////////////////////////
  task automatic t_timer;
    int n, m;
    rst_to(1'h1);
    wt(1'h1, 200*T, n);
    rng(n, 40*T, 120*T, "measure time");
    `CHK(en, 1'h1, "enable after measure");
    `CHK(tm, 1'h1, "timer mode");
    wt(1'h0, 200*T, n);
    rng(n, 49*T, 51*T, "pulse length");
    wt(1'h1, 200*T, m);
    rng(n + m, 98*T, 101*T, "period");
  endtask

  task automatic t_ack;
    int n, m;
    ack_dly = 10*T;
    wt(1'h0, 200*T, n);
    wt(1'h1, 200*T, m);
    wt(1'h0, 200*T, n);
    rng(n, 10*T, 10*T + 12, "ack drop");
    wt(1'h1, 200*T, m);
    rng(n + m, 98*T, 101*T, "acked period");
  endtask

  task automatic t_manual;
    int n, m;
    wt(1'h0, 200*T, n);
    pin <= 1'h1;
    wt(1'h1, 40*T, n);
    rng(n, 19*T, 31*T, "manual rise");
    hold(1'h1, 130*T, "manual hold");
    pin <= 1'h0;
    wt(1'h0, 200*T, n);
    rng(n, 68*T, 73*T, "after release");
    wt(1'h1, 200*T, m);
    rng(n + m, 116*T, 123*T, "restart count");
  endtask

  task automatic t_glitch;
    int n;
    wt(1'h0, 200*T, n);
    pin <= 1'h1;
    repeat (10*T) @(posedge clk);
    pin <= 1'h0;
    hold(1'h0, 50*T, "glitch");
  endtask

  task automatic t_ignore;
    int n;
    ack_dly = 0;
    wt(1'h1, 200*T, n);
    pin <= 1'h1;
    repeat (25*T) @(posedge clk);
    pin <= 1'h0;
    wt(1'h0, 200*T, n);
    rng(n + 25*T, 49*T, 51*T, "manual while high");
  endtask

  task automatic t_oneshot;
    int n, m;
    rst_to(1'h0);
    wt(1'h1, 200*T, n);
    `CHK(tm, 1'h0, "one-shot mode");
    wt(1'h0, 200*T, n);
    rng(n, 49*T, 51*T, "one-shot length");
    hold(1'h0, 250*T, "single pulse");
    ack_dly = 40*T;
    pin <= 1'h1;
    wt(1'h1, 40*T, m);
    rng(m, 19*T, 31*T, "one-shot manual");
    repeat (25*T - m) @(posedge clk);
    pin <= 1'h0;
    wt(1'h0, 200*T, n);
    rng(n + 25*T - m, 40*T, 40*T + 12, "one-shot ack");
    hold(1'h0, 250*T, "one more only");
  endtask

  task automatic t_abort;
    int n;
    ack_dly = 0;
    pin <= 1'h1;
    rst_to(1'h1);
    n = 0;
    while (ab !== 1'h1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(ab, 1'h1, "abort pulse");
    hold(1'h0, 60*T, "held in abort");
    pin <= 1'h0;
    wt(1'h1, 200*T, n);
    `CHK(en, 1'h1, "restarted");
  endtask

  initial
  begin
    repeat (3000*T) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    t_timer();
    t_ack();
    t_manual();
    t_glitch();
    t_ignore();
    t_oneshot();
    t_abort();
    tally_and_finish();
  end
endmodule
